// ===== ubgen_pkg.sv
package ubgen_pkg;
	// oscillator tick and bus clock, both in picoseconds
	localparam int unsigned TICK_PERIOD_PS = 62500;
	localparam int unsigned CLK_PERIOD_PS = 8000;
	// fractional tick accumulator, exact on average
	localparam logic [16:0] ACC_STEP = 17'(CLK_PERIOD_PS);
	localparam logic [16:0] ACC_WRAP = 17'(TICK_PERIOD_PS);
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_HIGH_A_UP = 8'hA6;
	localparam logic [7:0] IDX_HIGH_A_LO = 8'hA7;
	localparam logic [7:0] IDX_LOW_A_UP = 8'hA9;
	localparam logic [7:0] IDX_LOW_A_LO = 8'hAA;
	localparam logic [7:0] IDX_HIGH_B_UP = 8'hAB;
	localparam logic [7:0] IDX_HIGH_B_LO = 8'hAC;
	localparam logic [7:0] IDX_LOW_B_UP = 8'hAD;
	localparam logic [7:0] IDX_LOW_B_LO = 8'hAE;
	localparam logic [7:0] IDX_TOTAL_A = 8'hAF;
	localparam logic [7:0] IDX_TOTAL_B = 8'hB1;
	localparam logic [7:0] IDX_DEAD = 8'hB2;
	localparam logic [7:0] IDX_MODE = 8'hB3;
	localparam logic [7:0] IDX_CTRL = 8'hC0;
	localparam logic [7:0] IDX_STATUS = 8'hC1;
	// storage slots behind the indices
	localparam logic [3:0] SLOT_HIGH_A_UP = 4'h0;
	localparam logic [3:0] SLOT_HIGH_A_LO = 4'h1;
	localparam logic [3:0] SLOT_LOW_A_UP = 4'h2;
	localparam logic [3:0] SLOT_LOW_A_LO = 4'h3;
	localparam logic [3:0] SLOT_HIGH_B_UP = 4'h4;
	localparam logic [3:0] SLOT_HIGH_B_LO = 4'h5;
	localparam logic [3:0] SLOT_LOW_B_UP = 4'h6;
	localparam logic [3:0] SLOT_LOW_B_LO = 4'h7;
	localparam logic [3:0] SLOT_TOTAL_A = 4'h8;
	localparam logic [3:0] SLOT_TOTAL_B = 4'h9;
	localparam logic [3:0] SLOT_DEAD = 4'hA;
	localparam logic [3:0] SLOT_MODE = 4'hB;
	localparam logic [3:0] SLOT_CTRL = 4'hC;
	localparam logic [3:0] SLOT_STATUS = 4'hE;
	localparam logic [3:0] SLOT_NONE = 4'hF;
	localparam int SLOT_COUNT = 13;
	localparam logic [7:0] REG_RESET = 8'h00;
	// field positions
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_MANUAL_A_BIT = 1;
	localparam int CTRL_MANUAL_B_BIT = 2;
	// output configuration codes
	localparam logic [2:0] MODE_PUSH_PULL = 3'h0;
	localparam logic [2:0] MODE_GEN_A = 3'h1;
	localparam logic [2:0] MODE_GEN_B = 3'h2;
	localparam logic [2:0] MODE_GEN_BOTH = 3'h3;
	localparam logic [2:0] MODE_MANUAL = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_HIGH, ST_LOW} ubgen_state_t;
endpackage

// ===== ubgen_chan_if.sv
`timescale 1ns/1ps
interface ubgen_chan_if;
	logic [10:0] high_time; // high phase length in ticks
	logic [10:0] low_time; // low phase length in ticks
	logic [7:0] dead_time; // cut from end of high phase
	logic [5:0] pulse_total; // pulses per burst
	logic [10:0] delay; // ticks before first pulse
	logic enable; // channel generates in this mode
	logic start; // one-cycle burst start
	logic tick; // one-cycle oscillator tick
	logic drive; // generated level
	logic busy; // burst in progress
	modport ctrl (output high_time, low_time, dead_time, pulse_total,
		delay, enable, start, tick, input drive, busy);
	modport chan (input high_time, low_time, dead_time, pulse_total,
		delay, enable, start, tick, output drive, busy);
endinterface

// ===== ubgen_channel.sv
`timescale 1ns/1ps
module ubgen_channel
	import ubgen_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	ubgen_chan_if.chan ch
);
	ubgen_state_t state; // pulse sequencer
	logic [10:0] cnt; // ticks spent in phase
	logic [5:0] pulses; // pulses finished
	logic [11:0] cnt_next;
	assign cnt_next = {1'b0, cnt} + 12'h001;

	// sequencer; a zero-length phase still lasts one tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			cnt <= 11'h000;
			pulses <= 6'h00;
		end else begin
			unique case (state)
				ST_IDLE: begin
					// zero pulses means no burst at all
					if (ch.start && ch.enable && ch.pulse_total != 6'h00) begin
						cnt <= 11'h000;
						pulses <= 6'h00;
						state <= (ch.delay != 11'h000) ? ST_WAIT : ST_HIGH;
					end
				end
				ST_WAIT: if (ch.tick) begin
					if (cnt_next >= {1'b0, ch.delay}) begin
						cnt <= 11'h000;
						state <= ST_HIGH;
					end else cnt <= cnt_next[10:0];
				end
				ST_HIGH: if (ch.tick) begin
					if (cnt_next >= {1'b0, ch.high_time}) begin
						cnt <= 11'h000;
						state <= ST_LOW;
					end else cnt <= cnt_next[10:0];
				end
				ST_LOW: if (ch.tick) begin
					if (cnt_next >= {1'b0, ch.low_time}) begin
						cnt <= 11'h000;
						// last pulse done: back to idle, output low
						if ({1'b0, pulses} + 7'h01 >= {1'b0, ch.pulse_total})
							state <= ST_IDLE;
						else begin
							pulses <= pulses + 6'h01;
							state <= ST_HIGH;
						end
					end else cnt <= cnt_next[10:0];
				end
			endcase
		end
	end

	// dead time shaved off the tail of the high phase
	assign ch.drive = (state == ST_HIGH) &&
		({1'b0, cnt} + {4'h0, ch.dead_time} < {1'b0, ch.high_time});
	assign ch.busy = (state != ST_IDLE);

	////////////////////////////////////////////////////////////////////////
	// helper counters watched only by the checks
	ubgen_state_t prev_state;
	logic [11:0] hcount;
	logic [11:0] lcount;
	logic [6:0] pcount;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_state <= ST_IDLE;
			hcount <= 12'h000;
			lcount <= 12'h000;
			pcount <= 7'h00;
		end else begin
			prev_state <= state;
			hcount <= (state != ST_HIGH) ? 12'h000 : hcount + {11'h000, ch.tick};
			lcount <= (state != ST_LOW) ? 12'h000 : lcount + {11'h000, ch.tick};
			if (state == ST_IDLE && prev_state == ST_IDLE) pcount <= 7'h00;
			else if (state == ST_LOW && prev_state == ST_HIGH) pcount <= pcount + 7'h01;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_high_len;
		(state == ST_LOW && prev_state == ST_HIGH) |->
			hcount == ((ch.high_time == 11'h000) ? 12'h001 : {1'b0, ch.high_time});
	endproperty
	a_high_len: assert property (p_high_len) else $error("high phase length wrong");

	property p_low_len;
		(prev_state == ST_LOW && state != ST_LOW) |->
			$past(lcount) + 12'h001 ==
			((ch.low_time == 11'h000) ? 12'h001 : {1'b0, ch.low_time});
	endproperty
	a_low_len: assert property (p_low_len) else $error("low phase length wrong");

	// judged from the helper tick count, not from the phase counter
	property p_dead;
		(state == ST_HIGH) |->
			ch.drive == (hcount + {4'h0, ch.dead_time} < {1'b0, ch.high_time});
	endproperty
	a_dead: assert property (p_dead) else $error("drive level wrong in high phase");

	property p_pulse_total;
		(state == ST_IDLE && prev_state == ST_LOW) |-> pcount == {1'b0, ch.pulse_total};
	endproperty
	a_pulse_total: assert property (p_pulse_total) else $error("pulse count wrong");

	property p_idle_low;
		(state == ST_IDLE || state == ST_LOW) |-> !ch.drive;
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("drive high while idle or low");

	c_burst_done: cover property (state == ST_IDLE && prev_state == ST_LOW);
endmodule // ubgen_channel

// ===== ubgen_top.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ubgen_top
	import ubgen_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic drive_output_first,
	output logic drive_output_second
);
	////////////////////////////////////////////////////////////////////////
	// address decode

	// map a byte address to a storage slot
	function automatic logic [3:0] slot_of(input logic [11:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		slot_of = SLOT_NONE;
		// upper address bits must be clear
		if (addr[11:10] == 2'b00) begin
			case (idx)
				IDX_HIGH_A_UP: slot_of = SLOT_HIGH_A_UP;
				IDX_HIGH_A_LO: slot_of = SLOT_HIGH_A_LO;
				IDX_LOW_A_UP: slot_of = SLOT_LOW_A_UP;
				IDX_LOW_A_LO: slot_of = SLOT_LOW_A_LO;
				IDX_HIGH_B_UP: slot_of = SLOT_HIGH_B_UP;
				IDX_HIGH_B_LO: slot_of = SLOT_HIGH_B_LO;
				IDX_LOW_B_UP: slot_of = SLOT_LOW_B_UP;
				IDX_LOW_B_LO: slot_of = SLOT_LOW_B_LO;
				IDX_TOTAL_A: slot_of = SLOT_TOTAL_A;
				IDX_TOTAL_B: slot_of = SLOT_TOTAL_B;
				IDX_DEAD: slot_of = SLOT_DEAD;
				IDX_MODE: slot_of = SLOT_MODE;
				IDX_CTRL: slot_of = SLOT_CTRL;
				IDX_STATUS: slot_of = SLOT_STATUS;
				default: slot_of = SLOT_NONE;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// write channel

	logic aw_full; // write address captured
	logic w_full; // write data captured
	logic [11:0] awaddr_q; // held write address
	logic [31:0] wdata_q; // held write data
	logic [3:0] wstrb_q; // held byte enables
	logic write_fire; // both halves present, commit now
	logic [3:0] wslot; // decoded write target

	assign write_fire = aw_full && w_full && !s_axi_bvalid;
	assign wslot = slot_of(awaddr_q);

	// address and data taken in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			// address half
			if (s_axi_awready && s_axi_awvalid) begin
				awaddr_q <= s_axi_awaddr;
				aw_full <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			// data half
			if (s_axi_wready && s_axi_wvalid) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_full <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			// commit and answer; unmapped gets an error
			if (write_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wslot == SLOT_NONE) ? RESP_SLVERR : RESP_OKAY;
				aw_full <= 1'b0;
				w_full <= 1'b0;
			end
			// reopen only after the response is taken
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register storage

	logic [7:0] regs [SLOT_COUNT]; // all settings, byte per slot
	logic write_lane0; // byte lane that carries the register
	assign write_lane0 = write_fire && wstrb_q[0] && wslot < 4'(SLOT_COUNT);

	// every bit stored as written except the control start bit, spare upper bits included
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < SLOT_COUNT; i++)
				regs[i] <= REG_RESET;
		end else if (write_lane0) begin
			// start bit is a strobe, never stored
			if (wslot == SLOT_CTRL)
				regs[wslot] <= wdata_q[7:0] & ~(8'h01 << CTRL_START_BIT);
			else
				regs[wslot] <= wdata_q[7:0];
		end
	end

	logic start_pulse; // one cycle after a start write
	// start strobe from the control register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			start_pulse <= 1'b0;
		else
			start_pulse <= write_lane0 && wslot == SLOT_CTRL &&
				wdata_q[CTRL_START_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// read channel

	logic busy_a; // first channel bursting
	logic busy_b; // second channel bursting
	logic [3:0] rslot; // decoded read target
	logic [31:0] rvalue; // word to return
	assign rslot = slot_of(s_axi_araddr);

	// read mux; status is live, unmapped reads zero
	always_comb begin
		rvalue = 32'h0000_0000;
		if (rslot == SLOT_STATUS)
			rvalue = {30'h0000_0000, busy_b, busy_a};
		else if (rslot < 4'(SLOT_COUNT))
			rvalue = {24'h00_0000, regs[rslot]};
	end

	// data returned one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rvalue;
				s_axi_rresp <= (rslot == SLOT_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// oscillator tick

	logic [16:0] acc; // picoseconds toward next tick
	logic tick; // 62.5 ns tick, one cycle wide
	logic [16:0] acc_sum;
	assign acc_sum = acc + ACC_STEP;

	// tick spacing is 7 or 8 cycles, exact on average
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc <= 17'h0_0000;
			tick <= 1'b0;
		end else if (acc_sum >= ACC_WRAP) begin
			acc <= acc_sum - ACC_WRAP;
			tick <= 1'b1;
		end else begin
			acc <= acc_sum;
			tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channels

	logic [2:0] mode; // output configuration
	logic manual_a; // software level for first output
	logic manual_b; // software level for second output
	logic [10:0] high_a;
	assign mode = regs[SLOT_MODE][2:0];
	assign manual_a = regs[SLOT_CTRL][CTRL_MANUAL_A_BIT];
	assign manual_b = regs[SLOT_CTRL][CTRL_MANUAL_B_BIT];
	assign high_a = {regs[SLOT_HIGH_A_UP][2:0], regs[SLOT_HIGH_A_LO]};

	ubgen_chan_if chan_a ();
	ubgen_chan_if chan_b ();

	// settings for the first output
	assign chan_a.high_time = high_a;
	assign chan_a.low_time = {regs[SLOT_LOW_A_UP][2:0], regs[SLOT_LOW_A_LO]};
	assign chan_a.dead_time = regs[SLOT_DEAD];
	assign chan_a.pulse_total = regs[SLOT_TOTAL_A][5:0];
	assign chan_a.delay = 11'h000;
	assign chan_a.enable = (mode == MODE_PUSH_PULL) || (mode == MODE_GEN_A) ||
		(mode == MODE_GEN_BOTH);
	assign chan_a.tick = tick;
	// a start during a running burst is dropped
	assign chan_a.start = start_pulse && !busy_a && !busy_b;
	assign busy_a = chan_a.busy;

	// settings for the second output
	assign chan_b.high_time = {regs[SLOT_HIGH_B_UP][2:0], regs[SLOT_HIGH_B_LO]};
	assign chan_b.low_time = {regs[SLOT_LOW_B_UP][2:0], regs[SLOT_LOW_B_LO]};
	assign chan_b.dead_time = regs[SLOT_DEAD];
	assign chan_b.pulse_total = regs[SLOT_TOTAL_B][5:0];
	// push-pull: second output starts after the first high phase
	assign chan_b.delay = (mode == MODE_PUSH_PULL) ? high_a : 11'h000;
	assign chan_b.enable = (mode == MODE_PUSH_PULL) || (mode == MODE_GEN_B) ||
		(mode == MODE_GEN_BOTH);
	assign chan_b.tick = tick;
	assign chan_b.start = start_pulse && !busy_a && !busy_b;
	assign busy_b = chan_b.busy;

	ubgen_channel u_chan_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.ch(chan_a.chan)
	);

	ubgen_channel u_chan_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.ch(chan_b.chan)
	);

	////////////////////////////////////////////////////////////////////////
	// output select

	// reserved and illegal codes park both outputs low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drive_output_first <= 1'b0;
			drive_output_second <= 1'b0;
		end else begin
			unique case (mode)
				MODE_PUSH_PULL, MODE_GEN_BOTH: begin
					drive_output_first <= chan_a.drive;
					drive_output_second <= chan_b.drive;
				end
				MODE_GEN_A: begin
					drive_output_first <= chan_a.drive;
					drive_output_second <= manual_b;
				end
				MODE_GEN_B: begin
					drive_output_first <= manual_a;
					drive_output_second <= chan_b.drive;
				end
				MODE_MANUAL: begin
					drive_output_first <= manual_a;
					drive_output_second <= manual_b;
				end
				default: begin
					drive_output_first <= 1'b0;
					drive_output_second <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_reset_zero;
		$past(!aresetn) |-> (regs[SLOT_TOTAL_A] == 8'h00 &&
			regs[SLOT_HIGH_A_UP] == 8'h00 && mode == 3'h0);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("setting not zero after reset");

	property p_upper_stored;
		(write_lane0 && wslot == SLOT_HIGH_B_UP) |=>
			regs[SLOT_HIGH_B_UP] == $past(wdata_q[7:0]);
	endproperty
	a_upper_stored: assert property (p_upper_stored) else $error("upper byte not fully stored");

	property p_readback;
		(s_axi_arready && s_axi_arvalid && rslot == SLOT_TOTAL_B) |=>
			s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(regs[SLOT_TOTAL_B])};
	endproperty
	a_readback: assert property (p_readback) else $error("register readback wrong");

	property p_parked;
		(mode > MODE_MANUAL) |=> (!drive_output_first && !drive_output_second);
	endproperty
	a_parked: assert property (p_parked) else $error("output driven in reserved mode");

	property p_manual;
		(mode == MODE_MANUAL) |=> (drive_output_first == $past(manual_a) &&
			drive_output_second == $past(manual_b));
	endproperty
	a_manual: assert property (p_manual) else $error("manual level not passed");

	property p_follow_a;
		(mode == MODE_GEN_A) |=> drive_output_first == $past(chan_a.drive);
	endproperty
	a_follow_a: assert property (p_follow_a) else $error("first output not generated");

	property p_push_pull_wait;
		(chan_b.start && mode == MODE_PUSH_PULL && high_a > 11'h002) |=>
			!chan_b.drive [*8];
	endproperty
	a_push_pull_wait: assert property (p_push_pull_wait) else $error("second output early");

	c_write: cover property (write_fire && wslot == SLOT_CTRL);
	c_push_pull: cover property (mode == MODE_PUSH_PULL && drive_output_second);
	c_both: cover property (drive_output_first && busy_b);
endmodule // ubgen_top

// ===== ubgen_drive_model.sv
`timescale 1ns/1ps
// measures one gate line the way the low-side driver would see it
module ubgen_drive_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear, // restart counts for a new burst
	input wire logic level, // gate level from the block
	output logic [7:0] pulses, // rising edges seen
	output logic [15:0] high_len, // cycles of last high run
	output logic [15:0] low_len // cycles of last low run ended by a rise
);
	logic prev; // level at the previous edge
	logic [15:0] run; // cycles spent in the current level
	////////////////////////////////////////////////////////////////////////
	// run lengths; a pure load, so it never answers back
	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			prev <= 1'b0;
			run <= 16'h0000;
			pulses <= 8'h00;
			high_len <= 16'h0000;
			low_len <= 16'h0000;
		end else begin
			prev <= level;
			if (level !== prev) begin
				run <= 16'h0001;
				// a rise closes a low run, so idle time is overwritten later
				if (prev) begin
					high_len <= run;
				end else begin
					low_len <= run;
					pulses <= pulses + 8'h01;
				end
			end else begin
				run <= run + 16'h0001;
			end
		end
	end
endmodule // ubgen_drive_model

// ===== ultrasonic_burst_generator_bench.sv
`timescale 1ns/1ps
module ultrasonic_burst_generator_bench;
	import ubgen_pkg::*;
	typedef struct {
		logic [7:0] idx; // register index
		logic [7:0] wval; // byte written
		logic [7:0] rexp; // byte read back
		logic [1:0] resp; // answer on both channels
	} ubgen_row_t;
	logic aclk, aresetn, clr;
	logic [11:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata;
	logic [3:0] wstrb; // byte lanes of the write
	logic both_hi; // both gates seen on at once
	logic awready, wready, bvalid, arready, rvalid, out_a, out_b;
	logic [1:0] bresp, rresp, resp_q;
	logic [31:0] rdata, rdata_q;
	logic [7:0] pul_a, pul_b;
	logic [15:0] hi_a, hi_b, lo_a, lo_b;
	int err_count = 0;
	int check_count = 0;
	// storage rows; spare upper bits must hold what was written
	ubgen_row_t rows [14] = '{
		'{IDX_HIGH_A_UP, 8'hFF, 8'hFF, RESP_OKAY},
		'{IDX_HIGH_A_LO, 8'hA5, 8'hA5, RESP_OKAY},
		'{IDX_LOW_A_UP, 8'hFE, 8'hFE, RESP_OKAY},
		'{IDX_LOW_A_LO, 8'h5A, 8'h5A, RESP_OKAY},
		'{IDX_HIGH_B_UP, 8'hFD, 8'hFD, RESP_OKAY},
		'{IDX_HIGH_B_LO, 8'hC3, 8'hC3, RESP_OKAY},
		'{IDX_LOW_B_UP, 8'hFB, 8'hFB, RESP_OKAY},
		'{IDX_LOW_B_LO, 8'h3C, 8'h3C, RESP_OKAY},
		'{IDX_TOTAL_A, 8'hFF, 8'hFF, RESP_OKAY},
		'{IDX_TOTAL_B, 8'hC0, 8'hC0, RESP_OKAY},
		'{IDX_DEAD, 8'h81, 8'h81, RESP_OKAY},
		'{IDX_MODE, 8'hF8, 8'hF8, RESP_OKAY},
		'{IDX_STATUS, 8'hFF, 8'h00, RESP_OKAY},
		'{8'h10, 8'hFF, 8'h00, RESP_SLVERR}};
	// manual rows: {mode, ctrl, expected {second, first}}
	logic [19:0] mrows [8] = '{20'h04_02_1, 20'h04_04_2, 20'h01_04_2,
		20'h02_02_1, 20'h01_02_0, 20'h05_06_0, 20'h06_06_0, 20'h07_06_0};
	////////////////////////////////////////////////////////////////////////
	ubgen_top dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.drive_output_first(out_a), .drive_output_second(out_b));
	ubgen_drive_model mon_a (.aclk(aclk), .aresetn(aresetn), .clear(clr),
		.level(out_a), .pulses(pul_a), .high_len(hi_a), .low_len(lo_a));
	ubgen_drive_model mon_b (.aclk(aclk), .aresetn(aresetn), .clear(clr),
		.level(out_b), .pulses(pul_b), .high_len(hi_b), .low_len(lo_b));
	// overlap of the two gates, restarted with the monitors
	always @(posedge aclk) begin
		if (!aresetn || clr)
			both_hi <= 1'b0;
		else if (out_a && out_b)
			both_hi <= 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	// 8 ns clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// hang guard, far beyond the few thousand cycles the run needs
	initial begin
		#400000;
		err_count++;
		conclude;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		begin
			check_count++;
			if (seen !== exp) begin
				err_count++;
				$display("wrong value at %0t: seen %h expected %h", $time,
					seen, exp);
			end
		end
	endtask
	// run length must match a tick count, rounded either way by the accumulator
	task in_ticks(input logic [15:0] seen, input int t);
		logic [15:0] lo;
		begin
			lo = 16'(t * TICK_PERIOD_PS / CLK_PERIOD_PS);
			check(32'(seen >= lo && seen <= lo + 16'h0001), 32'h1);
		end
	endtask
	task conclude;
		begin
			$display("checks %0d errors %0d", check_count, err_count);
			if (err_count == 0 && check_count > 0) begin
				$display("*** PASS ***");
			end else begin
				$display("*** FAIL ***");
			end
			$finish;
		end
	endtask
	task rst;
		begin
			aresetn <= 1'b0;
			repeat (6) @(posedge aclk);
			aresetn <= 1'b1;
			@(posedge aclk);
		end
	endtask
	// one write; an edge passes first so no strobe is assigned twice
	task wr(input logic [7:0] idx, input logic [7:0] val);
		logic aw_ok, w_ok;
		begin
			@(posedge aclk);
			awaddr <= {2'b00, idx, 2'b00};
			wdata <= {24'h000000, val};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			aw_ok = 1'b0;
			w_ok = 1'b0;
			do begin
				@(posedge aclk);
				if (awready === 1'b1 && !aw_ok) begin
					aw_ok = 1'b1;
					awvalid <= 1'b0;
				end
				if (wready === 1'b1 && !w_ok) begin
					w_ok = 1'b1;
					wvalid <= 1'b0;
				end
			end while (!(aw_ok && w_ok));
			do @(posedge aclk); while (bvalid !== 1'b1);
			resp_q = bresp;
			bready <= 1'b0;
		end
	endtask
	task rd(input logic [7:0] idx);
		begin
			@(posedge aclk);
			araddr <= {2'b00, idx, 2'b00};
			arvalid <= 1'b1;
			rready <= 1'b1;
			do @(posedge aclk); while (arready !== 1'b1);
			arvalid <= 1'b0;
			do @(posedge aclk); while (rvalid !== 1'b1);
			rdata_q = rdata;
			resp_q = rresp;
			rready <= 1'b0;
		end
	endtask
	// start a burst and poll status until both channels are idle
	task burst(input logic [7:0] ta, input logic [7:0] tb);
		begin
			wr(IDX_TOTAL_A, ta);
			wr(IDX_TOTAL_B, tb);
			clr <= 1'b1;
			@(posedge aclk);
			clr <= 1'b0;
			wr(IDX_CTRL, 8'h01);
			rdata_q = 32'h1;
			while (rdata_q !== 32'h0) begin
				repeat (20) @(posedge aclk);
				rd(IDX_STATUS);
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clr <= 1'b0;
		wstrb <= 4'hF;
		awaddr <= 12'h000;
		araddr <= 12'h000;
		wdata <= 32'h0;
		{awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
		rst;
		// reset values, then table of write and read back
		for (int i = 0; i < 14; i++) begin
			rd(rows[i].idx);
			check(rdata_q, 32'h0);
		end
		for (int i = 0; i < 14; i++) begin
			wr(rows[i].idx, rows[i].wval);
			check(resp_q, rows[i].resp);
			rd(rows[i].idx);
			check(rdata_q, {24'h0, rows[i].rexp});
			check(resp_q, rows[i].resp);
		end
		// second reset clears what the table stored
		rst;
		rd(IDX_HIGH_A_UP);
		check(rdata_q, 32'h0);
		// square wave: high equals low, dead time of one tick
		wr(IDX_HIGH_A_LO, 8'h04);
		wr(IDX_LOW_A_LO, 8'h04);
		wr(IDX_HIGH_B_LO, 8'h04);
		wr(IDX_LOW_B_LO, 8'h04);
		wr(IDX_DEAD, 8'h01);
		wr(IDX_MODE, {5'h00, MODE_GEN_BOTH});
		burst(8'h02, 8'h03);
		check(pul_a, 8'h02);
		check(pul_b, 8'h03);
		in_ticks(hi_a, 3);
		in_ticks(lo_a, 5);
		in_ticks(hi_b, 3);
		in_ticks(lo_b, 5);
		check({out_b, out_a}, 2'b00);
		// counts at both ends of their range
		burst(8'h00, 8'h3F);
		check(pul_a, 8'h00);
		check(pul_b, 8'h3F);
		check({out_b, out_a}, 2'b00);
		// push-pull: second gate waits, the two never on together
		wr(IDX_MODE, {5'h00, MODE_PUSH_PULL});
		burst(8'h02, 8'h02);
		check(pul_a, 8'h02);
		check(pul_b, 8'h02);
		check(both_hi, 1'b0);
		in_ticks(hi_b, 3);
		// a write without the low byte lane stores nothing
		wstrb <= 4'hE;
		wr(IDX_DEAD, 8'h77);
		check(resp_q, RESP_OKAY);
		wstrb <= 4'hF;
		rd(IDX_DEAD);
		check(rdata_q, 32'h01);
		// manual and unused configurations
		for (int i = 0; i < 8; i++) begin
			wr(IDX_MODE, mrows[i][19:12]);
			wr(IDX_CTRL, mrows[i][11:4]);
			repeat (4) @(posedge aclk);
			check({out_b, out_a}, mrows[i][1:0]);
		end
		conclude;
	end
endmodule // ultrasonic_burst_generator_bench
